// [hw/dct_pkg.sv]
// Summary of operation
// - Read-only per-channel chain expiry status, set by bit 4
// - Software commands decode address, ignore data
// - Clear pointer first, then low byte, high byte
// - Two host pointers, cleared by 0C, 0D8
// - Shared bus-master pointer, cleared by master writes to 0C, 0D8
// - Master clear acts like reset per group
// - Port 0D clears low group, 0DA high
// - Expiry without reload/chain: status, mask, clear request
// - Expiry with reload: status, clear request, reload
// - Expiry with chain loaded: only reload from base
// - Stop limit sets mask only
// - Read-only last-master latch at port 046
// - Latch bits active low for last granted
// - Slot 7 and 8 bits always read high
// - Port 0465 reserved, not implemented
// - Chain bit 4 drives end-of-process on an event with assist while acknowledged
// - Count-done status clears on reset and host read
package dct_pkg;
  // Port addresses
  localparam logic [11:0] CLR_PTR_LO_ADDR = 12'h00C;
  localparam logic [11:0] MCLR_LO_ADDR    = 12'h00D;
  localparam logic [11:0] STATUS_LO_ADDR  = 12'h008;
  localparam logic [11:0] LAST_MST_ADDR   = 12'h046;
  localparam logic [11:0] CLR_PTR_HI_ADDR = 12'h0D8;
  localparam logic [11:0] MCLR_HI_ADDR    = 12'h0DA;
  localparam logic [11:0] STATUS_HI_ADDR  = 12'h0D0;
  localparam logic [11:0] CHAIN_EXP_ADDR  = 12'h40C;
  localparam logic [11:0] EXTRA_MST_ADDR  = 12'h465;
  // Field position of the expiry bit in a chaining-mode write
  localparam int          CHAIN_EXP_BIT   = 4;
  // Reset values
  localparam logic [7:0]  MASK_RST        = 8'hFF;
  localparam logic [7:0]  LATCH_RST       = 8'hFF;
  localparam logic [7:0]  ZERO8           = 8'h00;
  localparam logic [7:0]  SLOT78_HIGH     = 8'hC0;
endpackage

// [hw/dct_core.sv]
`timescale 1ns/1ps
module dct_core
  import dct_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  // I/O port access
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [11:0] io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  input  wire logic        io_mst_i,
  output logic      [7:0]  io_rdata_o,
  // Byte access to 16-bit address/count registers
  input  wire logic        wide_acc_i,
  input  wire logic        wide_grp_i,
  output logic             ptr_lo_grp_o,
  output logic             ptr_hi_grp_o,
  output logic             ptr_mst_o,
  // Chaining-mode write
  input  wire logic        chain_wr_i,
  input  wire logic [2:0]  chain_ch_i,
  // Per-channel events
  input  wire logic [7:0]  cnt_exp_i,
  input  wire logic [7:0]  end_of_process_input_i,
  input  wire logic [7:0]  stop_lim_i,
  input  wire logic [7:0]  autoreload_i,
  input  wire logic [7:0]  chain_loaded_i,
  input  wire logic [7:0]  sw_req_set_i,
  input  wire logic [7:0]  dack_n_i,
  input  wire logic [7:0]  mst_assist_i,
  output logic      [7:0]  reload_o,
  output logic      [7:0]  eop_out_o,
  // Group state
  output logic      [7:0]  mask_o,
  output logic      [7:0]  sw_req_o,
  output logic      [7:0]  count_done_status_o,
  output logic      [1:0]  grp_idle_o,
  // Bus master grant
  input  wire logic [7:0]  grant_n_i
);

  // Registered state
  logic [7:0] mask_r,   mask_nxt;    // Channel masks
  logic [7:0] req_r,    req_nxt;     // Software requests
  logic [7:0] tc_r,     tc_nxt;      // Count-done status
  logic [7:0] exp_r,    exp_nxt;     // Chain expiry control
  logic [7:0] cmd_r,    cmd_nxt;     // Command bits per channel group
  logic       plo_r,    plo_nxt;     // Host pointer, ch 0-3
  logic       phi_r,    phi_nxt;     // Host pointer, ch 4-7
  logic       pms_r,    pms_nxt;     // Shared bus-master pointer
  logic [7:0] latch_r,  latch_nxt;   // Last master latch
  logic [7:0] rd_r,     rd_nxt;      // Read data
  logic [7:0] rel_r,    rel_nxt;     // Reload pulses
  logic [7:0] eop_r,    eop_nxt;     // End-of-process drive
  logic [7:0] gnt_s1_r, gnt_s2_r;    // Grant synchroniser
  logic [7:0] dk_s1_r,  dk_s2_r;     // Acknowledge synchroniser

  // Decodes; data bus is ignored for commands
  logic clr_lo, clr_hi, mc_lo, mc_hi, st_rd_lo, st_rd_hi;
  logic [7:0] lo_grp, hi_grp, ev;
  always_comb begin
    clr_lo   = io_wr_i && io_addr_i == CLR_PTR_LO_ADDR;
    clr_hi   = io_wr_i && io_addr_i == CLR_PTR_HI_ADDR;
    mc_lo    = io_wr_i && io_addr_i == MCLR_LO_ADDR;
    mc_hi    = io_wr_i && io_addr_i == MCLR_HI_ADDR;
    // Only a host read clears status
    st_rd_lo = io_rd_i && !io_mst_i && io_addr_i == STATUS_LO_ADDR;
    st_rd_hi = io_rd_i && !io_mst_i && io_addr_i == STATUS_HI_ADDR;
    lo_grp   = 8'h0F;
    hi_grp   = 8'hF0;
    ev       = cnt_exp_i | end_of_process_input_i;
  end

  // Pin synchronisers; first stage read only by second
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gnt_s1_r <= LATCH_RST;
      gnt_s2_r <= LATCH_RST;
      dk_s1_r  <= LATCH_RST;
      dk_s2_r  <= LATCH_RST;
    end else begin
      gnt_s1_r <= grant_n_i;
      gnt_s2_r <= gnt_s1_r;
      dk_s1_r  <= dack_n_i;
      dk_s2_r  <= dk_s1_r;
    end
  end

  // Channel event and command next state
  always_comb begin
    mask_nxt = mask_r;
    req_nxt  = req_r | sw_req_set_i;
    tc_nxt   = tc_r;
    exp_nxt  = exp_r;
    cmd_nxt  = cmd_r;
    rel_nxt  = ZERO8;
    // read clears status; events below win
    if (st_rd_lo) tc_nxt = tc_nxt & hi_grp;
    if (st_rd_hi) tc_nxt = tc_nxt & lo_grp;
    // expiry control from chaining-mode bit 4
    if (chain_wr_i)
      exp_nxt[chain_ch_i] = io_wdata_i[CHAIN_EXP_BIT];
    for (int c = 0; c < 8; c++) begin
      if (ev[c]) begin
        if (autoreload_i[c]) begin
          tc_nxt[c]  = 1'b1;
          req_nxt[c] = 1'b0;
          rel_nxt[c] = 1'b1;
        end else if (chain_loaded_i[c]) begin
          rel_nxt[c] = 1'b1;
        end else begin
          tc_nxt[c]   = 1'b1;
          mask_nxt[c] = 1'b1;
          req_nxt[c]  = 1'b0;
        end
      end
      if (stop_lim_i[c]) mask_nxt[c] = 1'b1;
    end
    // master clear behaves as reset for its group
    if (mc_lo) begin
      mask_nxt = mask_nxt | lo_grp;
      req_nxt  = req_nxt & hi_grp;
      tc_nxt   = tc_nxt & hi_grp;
      cmd_nxt  = cmd_nxt & hi_grp;
      exp_nxt  = exp_nxt & hi_grp;
    end
    if (mc_hi) begin
      mask_nxt = mask_nxt | hi_grp;
      req_nxt  = req_nxt & lo_grp;
      tc_nxt   = tc_nxt & lo_grp;
      cmd_nxt  = cmd_nxt & lo_grp;
      exp_nxt  = exp_nxt & lo_grp;
    end
  end

  // Byte pointers and read path next state
  always_comb begin
    plo_nxt = plo_r;
    phi_nxt = phi_r;
    pms_nxt = pms_r;
    // toggle selected pointer per byte access
    if (wide_acc_i) begin
      if (io_mst_i)        pms_nxt = !pms_r;
      else if (wide_grp_i) phi_nxt = !phi_r;
      else                 plo_nxt = !plo_r;
    end
    // host pointers cleared per port; low byte next
    if (!io_mst_i && (clr_lo || mc_lo)) plo_nxt = 1'b0;
    if (!io_mst_i && (clr_hi || mc_hi)) phi_nxt = 1'b0;
    // master pointer cleared by either port
    if (io_mst_i && (clr_lo || clr_hi)) pms_nxt = 1'b0;
    // latch the most recent granted master
    latch_nxt = latch_r;
    if (gnt_s2_r != LATCH_RST)
      // active low, slots 7 and 8 high
      latch_nxt = gnt_s2_r | SLOT78_HIGH;
    eop_nxt = exp_r & mst_assist_i & ev & ~dk_s2_r;
    // reserved port and unmapped addresses read zero
    rd_nxt = ZERO8;
    if (io_rd_i) begin
      unique case (io_addr_i)
        STATUS_LO_ADDR:  rd_nxt = {req_r[3:0], tc_r[3:0]};
        STATUS_HI_ADDR:  rd_nxt = {req_r[7:4], tc_r[7:4]};
        LAST_MST_ADDR:   rd_nxt = latch_r;
        CHAIN_EXP_ADDR:  rd_nxt = exp_r;
        default:         rd_nxt = ZERO8;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_r  <= MASK_RST;
      req_r   <= ZERO8;
      tc_r    <= ZERO8;
      exp_r   <= ZERO8;
      cmd_r   <= ZERO8;
      plo_r   <= 1'b0;
      phi_r   <= 1'b0;
      pms_r   <= 1'b0;
      latch_r <= LATCH_RST;
      rd_r    <= ZERO8;
      rel_r   <= ZERO8;
      eop_r   <= ZERO8;
    end else begin
      mask_r  <= mask_nxt;
      req_r   <= req_nxt;
      tc_r    <= tc_nxt;
      exp_r   <= exp_nxt;
      cmd_r   <= cmd_nxt;
      plo_r   <= plo_nxt;
      phi_r   <= phi_nxt;
      pms_r   <= pms_nxt;
      latch_r <= latch_nxt;
      rd_r    <= rd_nxt;
      rel_r   <= rel_nxt;
      eop_r   <= eop_nxt;
    end
  end

  // Outputs from flip-flops
  always_comb begin
    io_rdata_o          = rd_r;
    ptr_lo_grp_o        = plo_r;
    ptr_hi_grp_o        = phi_r;
    ptr_mst_o           = pms_r;
    reload_o            = rel_r;
    eop_out_o           = eop_r;
    mask_o              = mask_r;
    sw_req_o            = req_r;
    count_done_status_o = tc_r;
    grp_idle_o          = {cmd_r[7:4] == 4'h0, cmd_r[3:0] == 4'h0};
  end

  // Assertions
  a_plain_term_masks: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cnt_exp_i[0] && !autoreload_i[0] && !chain_loaded_i[0])
      |=> (mask_r[0] && tc_r[0] && !req_r[0]))
    else $error("plain termination missed");
  a_reload_status: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (ev[2] && autoreload_i[2] && !mc_lo && !stop_lim_i[2])
      |=> (tc_r[2] && rel_r[2] && mask_r[2] == $past(mask_r[2])))
    else $error("reload result wrong");
  a_chain_only: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (ev[3] && !autoreload_i[3] && chain_loaded_i[3] && !mc_lo
      && !stop_lim_i[3] && !st_rd_lo)
      |=> (rel_r[3] && tc_r[3] == $past(tc_r[3])))
    else $error("chain load touched status");
  a_stop_masks: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    stop_lim_i[4] && !ev[4] |=> mask_r[4] && !rel_r[4])
    else $error("stop limit mask missing");
  a_mclr_lo: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    mc_lo |=> (mask_r[3:0] == 4'hF) && !plo_r)
    else $error("master clear incomplete");
  a_ptr_clear: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    clr_hi && !io_mst_i |=> !phi_r)
    else $error("high pointer not cleared");
  a_mst_ptr: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (clr_lo || clr_hi) && io_mst_i |=> !pms_r)
    else $error("master pointer not cleared");
  a_slot78_high: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    latch_r[7:6] == 2'b11)
    else $error("slot 7/8 bit low");
  a_ptr_toggle: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    wide_acc_i && !io_mst_i && !wide_grp_i && !clr_lo && !mc_lo
      |=> plo_r != $past(plo_r))
    else $error("pointer did not toggle");
  a_eop_dack: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    eop_r[0] |-> !$past(dk_s2_r[0]))
    else $error("eop without acknowledge");
endmodule

// [test/dct_host_model.sv]
`timescale 1ns/1ps
// Host or bus-master side of the I/O port bus
module dct_host_model (
  // Clock
  input  wire logic        clk_i,
  // Port bus
  output logic             io_wr_o,
  output logic             io_rd_o,
  output logic      [11:0] io_addr_o,
  output logic      [7:0]  io_wdata_o,
  output logic             io_mst_o,
  input  wire logic [7:0]  io_rdata_i,
  // Byte access and chaining write
  output logic             wide_acc_o,
  output logic             wide_grp_o,
  output logic             chain_wr_o,
  output logic      [2:0]  chain_ch_o
);
  // Idle bus at time zero
  initial begin
    {io_wr_o, io_rd_o, io_mst_o, wide_acc_o, wide_grp_o} = 5'h00;
    {chain_wr_o, chain_ch_o, io_addr_o, io_wdata_o} = 24'h000000;
  end
  // Owner of the bus, changed only between transfers
  task automatic set_mst(input logic m);
    @(posedge clk_i);
    io_mst_o <= m;
  endtask
  // port write, data may carry anything
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    io_addr_o  <= a;
    io_wdata_o <= d;
    io_wr_o    <= 1'b1;
    @(posedge clk_i);
    io_wr_o    <= 1'b0;
    // Released data lines never hold the last value
    io_wdata_o <= ~d;
  endtask
  // Port read, data taken the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_i);
    io_addr_o <= a;
    io_rd_o   <= 1'b1;
    @(posedge clk_i);
    io_rd_o   <= 1'b0;
    #1 d = io_rdata_i;
  endtask
  // one byte of a 16-bit register
  task automatic wacc(input logic g);
    @(posedge clk_i);
    wide_grp_o <= g;
    wide_acc_o <= 1'b1;
    @(posedge clk_i);
    wide_acc_o <= 1'b0;
    #1;
  endtask
  // Chaining-mode write for one channel
  task automatic chain(input logic [2:0] ch, input logic [7:0] d);
    @(posedge clk_i);
    chain_ch_o <= ch;
    io_wdata_o <= d;
    chain_wr_o <= 1'b1;
    @(posedge clk_i);
    chain_wr_o <= 1'b0;
    io_wdata_o <= ~d;
  endtask
endmodule

// [test/dma_commands_and_tc_handling_tb.sv]
`timescale 1ns/1ps
// Bench for software commands and count-done handling
module dma_commands_and_tc_handling_tb;
  import dct_pkg::*;
  logic        clk = 1'b0;      // 20 MHz clock
  logic        arst_n = 1'b0;   // Async reset, low
  logic        io_wr, io_rd, io_mst, wide_acc, wide_grp, chain_wr, seen;
  logic        ptr_lo, ptr_hi, ptr_mst;
  logic [2:0]  chain_ch;
  logic [11:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, rv, reload, eop_out, mask, sw_req, done;
  logic [7:0]  cnt_exp, eop_in, stop_lim;     // Event pulses
  logic [7:0]  autoreload, chain_ld, req_set; // Channel conditions
  logic [7:0]  dack_n, assist, grant_n;       // Pins and assist levels
  int          fail_count = 0;
  int          samples_checked = 0;
  // Clock generator
  always #25 clk = ~clk;
  dct_host_model P (.clk_i(clk), .io_wr_o(io_wr), .io_rd_o(io_rd),
    .io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_mst_o(io_mst),
    .io_rdata_i(io_rdata), .wide_acc_o(wide_acc), .wide_grp_o(wide_grp),
    .chain_wr_o(chain_wr), .chain_ch_o(chain_ch));
  dct_core DUT (.core_clk_i(clk), .arst_n_i(arst_n), .io_wr_i(io_wr),
    .io_rd_i(io_rd), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
    .io_mst_i(io_mst), .io_rdata_o(io_rdata), .wide_acc_i(wide_acc),
    .wide_grp_i(wide_grp), .ptr_lo_grp_o(ptr_lo), .ptr_hi_grp_o(ptr_hi),
    .ptr_mst_o(ptr_mst), .chain_wr_i(chain_wr), .chain_ch_i(chain_ch),
    .cnt_exp_i(cnt_exp), .end_of_process_input_i(eop_in),
    .stop_lim_i(stop_lim), .autoreload_i(autoreload),
    .chain_loaded_i(chain_ld), .sw_req_set_i(req_set), .dack_n_i(dack_n),
    .mst_assist_i(assist), .reload_o(reload), .eop_out_o(eop_out),
    .mask_o(mask), .sw_req_o(sw_req), .count_done_status_o(done),
    .grp_idle_o(), .grant_n_i(grant_n));
  // Compare one value
  task automatic chk(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle channel events
  task automatic fire(input logic [7:0] rq, ce, ep, sl);
    @(posedge clk);
    req_set  <= rq;
    cnt_exp  <= ce;
    eop_in   <= ep;
    stop_lim <= sl;
    @(posedge clk);
    {req_set, cnt_exp, eop_in, stop_lim} <= 32'h00000000;
    #1;
  endtask
  // Single end of the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog, about fourteen times the expected run
  initial begin
    #(50 * 1200);
    fail_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    // Quiet event and pin levels while reset is held
    {cnt_exp, eop_in, stop_lim} = 24'h000000;
    {autoreload, chain_ld, req_set} = 24'h000000;
    {dack_n, assist, grant_n} = 24'hFF00FF;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    #1 chk("mask", MASK_RST, mask);
    P.rd(LAST_MST_ADDR, rv);
    chk("latch", LATCH_RST, rv);
    P.rd(EXTRA_MST_ADDR, rv);
    chk("extra", ZERO8, rv);
    repeat (3) P.wacc(1'b0);
    P.wacc(1'b1);
    chk("ptrs", 8'h03, {ptr_hi, ptr_lo});
    P.wr(CLR_PTR_LO_ADDR, 8'hA5);
    #1 chk("ptrs", 8'h02, {ptr_hi, ptr_lo});
    P.set_mst(1'b1);
    P.wacc(1'b0);
    chk("ptrs", 8'h06, {ptr_mst, ptr_hi, ptr_lo});
    P.wr(CLR_PTR_HI_ADDR, 8'h5A);
    #1 chk("ptrs", 8'h02, {ptr_mst, ptr_hi, ptr_lo});
    P.set_mst(1'b0);
    P.wr(CLR_PTR_HI_ADDR, 8'hFF);
    #1 chk("ptrs", 8'h00, {ptr_mst, ptr_hi, ptr_lo});
    autoreload <= 8'h04;
    chain_ld   <= 8'h08;
    fire(8'h0E, 8'h00, 8'h00, 8'h00);
    fire(8'h00, 8'h06, 8'h08, 8'h00);
    chk("done", 8'h06, done);
    chk("req", 8'h08, sw_req);
    chk("reload", 8'h0C, reload);
    fire(8'h00, 8'h00, 8'h00, 8'h10);
    chk("done", 8'h06, done);
    chk("mask", MASK_RST, mask);
    P.set_mst(1'b1);
    P.rd(STATUS_LO_ADDR, rv);
    chk("status", 8'h86, rv);
    P.set_mst(1'b0);
    P.rd(STATUS_LO_ADDR, rv);
    chk("done", 8'h00, done);
    fire(8'h22, 8'h10, 8'h00, 8'h00);
    P.wr(MCLR_LO_ADDR, 8'h00);
    #1 chk("req", 8'h20, sw_req);
    chk("done", 8'h10, done);
    P.wr(MCLR_HI_ADDR, 8'h3C);
    #1 chk("req", 8'h00, sw_req | done);
    P.chain(3'h0, 8'h10);
    P.rd(CHAIN_EXP_ADDR, rv);
    chk("chain", 8'h01, rv);
    assist <= 8'h01;
    dack_n <= 8'hFE;
    fire(8'h00, 8'h00, 8'h00, 8'h00);
    fire(8'h00, 8'h01, 8'h00, 8'h00);
    // Output stands one cycle, already up when fire returns
    seen = eop_out[0];
    repeat (4) begin
      @(posedge clk);
      #1 seen = seen | eop_out[0];
    end
    chk("eop", 8'h01, {7'h00, seen});
    grant_n <= 8'h7F;
    repeat (4) @(posedge clk);
    grant_n <= 8'hFF;
    P.rd(LAST_MST_ADDR, rv);
    chk("latch", 8'hFF, rv);
    grant_n <= 8'hFB;
    repeat (4) @(posedge clk);
    grant_n <= 8'hFF;
    P.rd(LAST_MST_ADDR, rv);
    chk("latch", 8'hFB, rv);
    report_and_stop();
  end
endmodule
